// ==== inc/tls_params.svh ====
// constants for the tape load sequencer
`ifndef TLS_PARAMS_SVH
`define TLS_PARAMS_SVH

// clock rate
`define TLS_CLK_MHZ 200

// durations in microseconds
`define TLS_DEBOUNCE_US 2000
`define TLS_LOAD_DELAY_US 500000
`define TLS_FAULT_US 4000000
`define TLS_HOLD_US 3000000

// register byte addresses
`define TLS_ADDR_CTRL 4'h0
`define TLS_ADDR_STATUS 4'h4

// control field positions
`define TLS_CTRL_DOUBLE 0
`define TLS_CTRL_CLR_LOADED 1
`define TLS_CTRL_OP_RESET 2

// reset values
`define TLS_CTRL_RESET 1'h0
`define TLS_STATUS_PAD 24'h000000
`define TLS_WORD_ZERO 32'h00000000

// timer counter width
`define TLS_CNT_W 32

`endif

// ==== inc/tls_pkg.sv ====
// types shared by the tape load sequencer
package tls_pkg;

  typedef struct packed {
    logic load_lamp;
    logic motor_relay;
    logic hold_expired;
    logic load_fault_n;
    logic load_delay_done;
    logic loaded_flag;
    logic threading_latch;
    logic vacuum_load_latch;
  } tls_status_s;

  typedef struct packed {
    logic pull_in;
    logic fault;
    logic hold;
  } tls_expire_s;

endpackage

// ==== core/tls_timer.sv ====
// elapsed-time counter, held clear while not running
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_timer #(
  parameter logic [`TLS_CNT_W-1:0] LIMIT = 32'h00000010
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // control
  input wire logic run_in,
  // results
  output logic done_out,
  output logic expire_out
);

  logic [`TLS_CNT_W-1:0] cnt_q;

  // counting stops at the limit so done stays a level
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !run_in) begin
      cnt_q <= '0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !run_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_q == LIMIT);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in || !run_in) begin
      expire_out <= 1'b0;
    end else begin
      expire_out <= (cnt_q == LIMIT - 1'b1);
    end
  end

endmodule

// ==== core/tls_debounce.sv ====
// switch synchroniser and debouncer, one pulse per press and release
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_debounce #(
  parameter logic [`TLS_CNT_W-1:0] STABLE = 32'h00000010
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // raw switch, high while pressed
  input wire logic sw_in,
  // one-cycle pulse on release after a press
  output logic pulse_out
);

  logic meta_q;
  logic sync_q;
  logic stable_q;
  logic [`TLS_CNT_W-1:0] cnt_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= sw_in;
      sync_q <= meta_q;
    end
  end

  // contact bounce shorter than the window is ignored
  always_ff @(posedge core_clk_in) begin
    if (rst_in || sync_q == stable_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      stable_q <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= 1'b0;
      if (sync_q != stable_q && cnt_q == STABLE) begin
        stable_q <= sync_q;
        pulse_out <= stable_q;
      end
    end
  end

endmodule

// ==== core/tls_sequencer.sv ====
// load sequence controller for a vacuum-column tape unit
// Behaviour
// R1 - a press and release of load sets the vacuum load latch
// R2 - threading latch held off while operator reset chain is active
// R3 - vacuum relay energized while the vacuum load latch is set
// R4 - reel pull-in low only with latch, interlock term and delay done
// R5 - load delay timer runs from the latch, done after it elapses
// R6 - reel drive commanded while reel pull-in is asserted
// R7 - fault timer from pull-in; expiry drops fault, aborts the load
// R8 - interlock before expiry ends pull-in, resets timer, no fault
// R9 - vacuum switches with latch assert motor connect, hold, relay
// R10 - interlock hold with power good keeps motor relay energized
// R11 - hold expiry sets hold-expired latch, clearing the vacuum latch
// R12 - single load: latch clear while unloaded sets threading, loaded
// R13 - double load: second press while unloaded sets threading, loaded
// R14 - threading latch requests forward capstan motion
// R15 - marker rise while threading clears it, stops tape, lights lamp
// R16 - blower runs exactly while the vacuum relay is energized
// R17 - power good releases relay latch and control state
// R18 - marker stop reset also from its chain, drives rewind clear
// R19 - load switch synchronised, debounced, one pulse per press
// R20 - timer durations are parameters counted in clock cycles
`timescale 1ns/100ps
`include "tls_params.svh"

module tls_sequencer #(
  // R20 durations in cycles
  parameter logic [`TLS_CNT_W-1:0] DEBOUNCE_CYC =
    `TLS_CNT_W'(`TLS_DEBOUNCE_US * `TLS_CLK_MHZ),
  parameter logic [`TLS_CNT_W-1:0] LOAD_DELAY_CYC =
    `TLS_CNT_W'(`TLS_LOAD_DELAY_US * `TLS_CLK_MHZ),
  parameter logic [`TLS_CNT_W-1:0] FAULT_CYC =
    `TLS_CNT_W'(`TLS_FAULT_US * `TLS_CLK_MHZ),
  parameter logic [`TLS_CNT_W-1:0] HOLD_CYC =
    `TLS_CNT_W'(`TLS_HOLD_US * `TLS_CLK_MHZ)
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // avalon-mm slave
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // operator and sensors
  input wire logic load_switch_in,
  input wire logic operator_reset_in,
  input wire logic [1:0] vacuum_switch_in,
  input wire logic marker_detected_in,
  input wire logic power_good_reset_in,
  // relays and drives
  output logic vacuum_relay_out,
  output logic blower_out,
  output logic motor_relay_out,
  output logic reel_pull_in_n_out,
  output logic reel_drive_out,
  output logic capstan_fwd_out,
  // status lines
  output logic load_fault_n_out,
  output logic motor_connect_n_out,
  output logic rewind_clear_out,
  output logic load_lamp_out
);

  logic load_pulse;
  logic delay_done;
  logic fault_done;
  logic fault_expire;
  logic hold_expire;
  logic power_good;

  logic vacuum_load_latch_q;
  logic threading_latch_q;
  logic loaded_flag_q;
  logic load_fault_n_q;
  logic hold_expired_q;
  logic hold_run_q;
  logic motor_relay_q;
  logic load_lamp_q;
  logic motor_connect_n_q;
  logic marker_q;
  logic double_load_q;
  logic sw_clr_loaded_q;
  logic sw_op_reset_q;

  logic vacuum_switch_closed;
  logic interlock_active;
  logic interlock_hold;
  logic operator_reset_chain;
  logic reel_pull_in;
  logic motor_connect;
  logic marker_rise;
  logic marker_stop_reset;
  logic vac_clear;
  logic vac_set;
  logic thread_set;
  tls_pkg::tls_status_s status;

  // R19 load switch debounce
  tls_debounce #(
    .STABLE(DEBOUNCE_CYC)
  ) u_load_sw (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .sw_in(load_switch_in),
    .pulse_out(load_pulse)
  );

  // R5 load delay timer
  tls_timer #(
    .LIMIT(LOAD_DELAY_CYC)
  ) u_delay (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(vacuum_load_latch_q),
    .done_out(delay_done),
    .expire_out()
  );

  // R7 load fault timer
  tls_timer #(
    .LIMIT(FAULT_CYC)
  ) u_fault (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(reel_pull_in),
    .done_out(fault_done),
    .expire_out(fault_expire)
  );

  // R11 hold single shot
  tls_timer #(
    .LIMIT(HOLD_CYC)
  ) u_hold (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(hold_run_q),
    .done_out(),
    .expire_out(hold_expire)
  );

  // R17 power good qualifies the sequence latches, not the edge flops, the output flops or the control register
  assign power_good = power_good_reset_in;

  assign vacuum_switch_closed = &vacuum_switch_in;

  // R10 interlock hold term
  assign interlock_hold = motor_relay_q & vacuum_switch_closed;

  // high until the relay pulls in with the loop in range
  assign interlock_active = ~interlock_hold;

  // R2 reset chain
  assign operator_reset_chain = operator_reset_in | sw_op_reset_q |
    ~motor_relay_q;

  // R4 pull-in gate, R8 interlock ends it
  assign reel_pull_in = vacuum_load_latch_q & interlock_active &
    delay_done & load_fault_n_q;

  // R9 motor connect
  assign motor_connect = vacuum_load_latch_q & vacuum_switch_closed;

  // R15 marker edge while threading
  assign marker_rise = marker_detected_in & ~marker_q;

  // R18 marker stop reset and its chain
  assign marker_stop_reset = (marker_rise & threading_latch_q) |
    operator_reset_in | sw_op_reset_q;

  // R7 abort and R11 hold expiry clear the vacuum latch
  assign vac_clear = fault_expire | hold_expire;

  // R1 first press starts the sequence
  assign vac_set = load_pulse & ~vacuum_load_latch_q &
    ~loaded_flag_q & operator_reset_chain;

  // R12 single load, R13 double load
  always_comb begin
    thread_set = 1'b0;
    if (!loaded_flag_q && !operator_reset_chain) begin
      if (double_load_q) begin
        thread_set = load_pulse;
      end else begin
        thread_set = hold_expire & vacuum_load_latch_q;
      end
    end
  end

  // R1 vacuum load latch, R7 R11 clears win over a press
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      vacuum_load_latch_q <= 1'b0;
    end else if (vac_clear) begin
      vacuum_load_latch_q <= 1'b0;
    end else if (vac_set) begin
      vacuum_load_latch_q <= 1'b1;
    end
  end

  // R2 R14 R15 threading latch
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      threading_latch_q <= 1'b0;
    end else if (marker_stop_reset || operator_reset_chain) begin
      threading_latch_q <= 1'b0;
    end else if (thread_set) begin
      threading_latch_q <= 1'b1;
    end
  end

  // R12 R13 loaded flag, set wins over software clear
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      loaded_flag_q <= 1'b0;
    end else if (thread_set) begin
      loaded_flag_q <= 1'b1;
    end else if (sw_clr_loaded_q || operator_reset_in) begin
      loaded_flag_q <= 1'b0;
    end
  end

  // R7 fault stays low until the next load attempt
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      load_fault_n_q <= 1'b1;
    end else if (fault_expire) begin
      load_fault_n_q <= 1'b0;
    end else if (vac_set) begin
      load_fault_n_q <= 1'b1;
    end
  end

  // R9 hold single shot trigger on motor connect edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      hold_run_q <= 1'b0;
    end else if (hold_expire) begin
      hold_run_q <= 1'b0;
    end else if (motor_connect && motor_connect_n_q) begin
      hold_run_q <= 1'b1;
    end
  end

  // R11 hold expired latch
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      hold_expired_q <= 1'b0;
    end else if (hold_expire) begin
      hold_expired_q <= 1'b1;
    end else if (vac_set) begin
      hold_expired_q <= 1'b0;
    end
  end

  // R9 R10 R17 motor relay latch
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      motor_relay_q <= 1'b0;
    end else begin
      motor_relay_q <= motor_connect | interlock_hold;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      motor_connect_n_q <= 1'b1;
      marker_q <= 1'b0;
    end else begin
      motor_connect_n_q <= ~motor_connect;
      marker_q <= marker_detected_in;
    end
  end

  // R15 load lamp lights at the marker stop
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !power_good) begin
      load_lamp_q <= 1'b0;
    end else if (marker_rise && threading_latch_q) begin
      load_lamp_q <= 1'b1;
    end else if (!loaded_flag_q) begin
      load_lamp_q <= 1'b0;
    end
  end

  // R3 R16 relay and drive outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      vacuum_relay_out <= 1'b0;
      blower_out <= 1'b0;
      motor_relay_out <= 1'b0;
    end else begin
      vacuum_relay_out <= vacuum_load_latch_q;
      blower_out <= vacuum_load_latch_q;
      motor_relay_out <= motor_relay_q;
    end
  end

  // R4 R6 R14 drive outputs
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reel_pull_in_n_out <= 1'b1;
      reel_drive_out <= 1'b0;
      capstan_fwd_out <= 1'b0;
    end else begin
      reel_pull_in_n_out <= ~reel_pull_in;
      reel_drive_out <= reel_pull_in;
      capstan_fwd_out <= threading_latch_q & ~marker_stop_reset;
    end
  end

  // R18 rewind clear follows the marker stop reset
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      load_fault_n_out <= 1'b1;
      motor_connect_n_out <= 1'b1;
      rewind_clear_out <= 1'b0;
      load_lamp_out <= 1'b0;
    end else begin
      load_fault_n_out <= load_fault_n_q;
      motor_connect_n_out <= ~motor_connect;
      rewind_clear_out <= marker_stop_reset;
      load_lamp_out <= load_lamp_q;
    end
  end

  // control register; strobes last one cycle, committed at the answer edge
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      double_load_q <= `TLS_CTRL_RESET;
      sw_clr_loaded_q <= 1'b0;
      sw_op_reset_q <= 1'b0;
    end else begin
      sw_clr_loaded_q <= 1'b0;
      sw_op_reset_q <= 1'b0;
      if (avs_write_in && !avs_waitrequest_out &&
          avs_address_in == `TLS_ADDR_CTRL && avs_byteenable_in[0]) begin
        double_load_q <= avs_writedata_in[`TLS_CTRL_DOUBLE];
        sw_clr_loaded_q <= avs_writedata_in[`TLS_CTRL_CLR_LOADED];
        sw_op_reset_q <= avs_writedata_in[`TLS_CTRL_OP_RESET];
      end
    end
  end

  assign status = '{
    load_lamp: load_lamp_q,
    motor_relay: motor_relay_q,
    hold_expired: hold_expired_q,
    load_fault_n: load_fault_n_q,
    load_delay_done: delay_done,
    loaded_flag: loaded_flag_q,
    threading_latch: threading_latch_q,
    vacuum_load_latch: vacuum_load_latch_q
  };

  // one wait cycle keeps read data straight from a flop
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // unmapped addresses read as zero
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= `TLS_WORD_ZERO;
    end else if (avs_read_in && avs_waitrequest_out) begin
      case (avs_address_in)
        `TLS_ADDR_CTRL: begin
          avs_readdata_out <= {31'h00000000, double_load_q};
        end
        `TLS_ADDR_STATUS: begin
          avs_readdata_out <= {`TLS_STATUS_PAD, status};
        end
        default: begin
          avs_readdata_out <= `TLS_WORD_ZERO;
        end
      endcase
    end
  end

  // fault_done is only a level view of the same timer
  logic unused_ok;
  assign unused_ok = fault_done & interlock_active;

endmodule

// ==== bench/tls_seq_properties.sv ====
// port assertions for the tape load sequencer
`timescale 1ns/100ps
module tls_seq_properties #(
  parameter logic [31:0] LOAD_DELAY_CYC = 32'h00000014,
  parameter logic [31:0] FAULT_CYC = 32'h00000028
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // operator and sensors
  input wire logic operator_reset_in,
  input wire logic marker_detected_in,
  input wire logic power_good_reset_in,
  // relays, drives and status
  input wire logic vacuum_relay_out,
  input wire logic blower_out,
  input wire logic motor_relay_out,
  input wire logic reel_pull_in_n_out,
  input wire logic reel_drive_out,
  input wire logic capstan_fwd_out,
  input wire logic load_fault_n_out,
  input wire logic motor_connect_n_out,
  input wire logic rewind_clear_out,
  input wire logic load_lamp_out
);
  logic [31:0] vac_cnt_q;
  logic [31:0] pull_cnt_q;
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  // run lengths, so timer figures can be checked at the ports
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !vacuum_relay_out) vac_cnt_q <= 32'h00000000;
    else vac_cnt_q <= vac_cnt_q + 32'h00000001;
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in || reel_pull_in_n_out) pull_cnt_q <= 32'h00000000;
    else pull_cnt_q <= pull_cnt_q + 32'h00000001;
  end
  blower_follow_a: assert property (blower_out == vacuum_relay_out)
    else $error("blower mismatch");
  reel_drive_a: assert property (reel_drive_out != reel_pull_in_n_out)
    else $error("reel drive mismatch");
  pull_gate_a: assert property (
    !reel_pull_in_n_out |-> vacuum_relay_out)
    else $error("pull-in without latch");
  delay_first_a: assert property (
    $fell(reel_pull_in_n_out) |-> vac_cnt_q >= LOAD_DELAY_CYC)
    else $error("pull-in before delay");
  fault_time_a: assert property (
    $fell(load_fault_n_out) |-> pull_cnt_q + 32'h00000002 >= FAULT_CYC)
    else $error("fault too early");
  fault_abort_a: assert property (
    $fell(load_fault_n_out) |->
      ##[0:3] (!vacuum_relay_out && reel_pull_in_n_out))
    else $error("fault did not abort");
  connect_relay_a: assert property (
    $fell(motor_connect_n_out) |-> ##[0:2] motor_relay_out)
    else $error("relay missed connect");
  power_drop_a: assert property (
    motor_relay_out && !power_good_reset_in |-> ##[1:2] !motor_relay_out)
    else $error("relay held without power");
  marker_stop_a: assert property (
    $rose(marker_detected_in) && capstan_fwd_out |->
      ##[1:4] (!capstan_fwd_out && load_lamp_out))
    else $error("marker did not stop");
  rewind_pulse_a: assert property (
    $rose(marker_detected_in) && capstan_fwd_out |->
      ##[1:4] rewind_clear_out)
    else $error("no rewind clear");
  op_reset_a: assert property (
    operator_reset_in |-> ##[1:4] !capstan_fwd_out)
    else $error("threading not held off");
  cover property ($fell(load_fault_n_out));
  cover property ($rose(capstan_fwd_out));
  cover property ($rose(load_lamp_out));
endmodule

bind tls_sequencer tls_seq_properties #(
  .LOAD_DELAY_CYC(LOAD_DELAY_CYC),
  .FAULT_CYC(FAULT_CYC)
) chk (
  .core_clk_in, .rst_in, .operator_reset_in, .marker_detected_in,
  .power_good_reset_in, .vacuum_relay_out, .blower_out, .motor_relay_out,
  .reel_pull_in_n_out, .reel_drive_out, .capstan_fwd_out,
  .load_fault_n_out, .motor_connect_n_out, .rewind_clear_out,
  .load_lamp_out
);

// ==== bench/tls_far_side.sv ====
// tape path model: vacuum switches and marker sensor
`timescale 1ns/100ps
module tls_far_side #(
  parameter int DRAW_CYC = 8,
  parameter int MARK_CYC = 30
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // low keeps the tape out of the columns
  input wire logic draw_en_in,
  // drives
  input wire logic reel_drive_in,
  input wire logic capstan_fwd_in,
  // sensors
  output logic [1:0] vacuum_switch_out,
  output logic marker_out
);
  int draw_q;
  int cap_q;
  // switches close one column at a time as the reels pull tape in
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !draw_en_in) draw_q <= 0;
    else if (reel_drive_in && draw_q < DRAW_CYC) draw_q <= draw_q + 1;
  end
  assign vacuum_switch_out = (draw_q >= DRAW_CYC) ? 2'h3 :
    (draw_q >= DRAW_CYC / 2) ? 2'h1 : 2'h0;
  // tape stops on the marker, so it stays seen until unloaded
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !draw_en_in) cap_q <= 0;
    else if (capstan_fwd_in && cap_q < MARK_CYC) cap_q <= cap_q + 1;
  end
  assign marker_out = (cap_q >= MARK_CYC);
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the tape load sequencer
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [3:0] a;
    logic [3:0] be;
    logic wr;
    logic [31:0] d;
    logic [31:0] exp;
  } tls_row_s;
  localparam int DEB = 4;
  localparam int LAMP = 6, CAP = 5, MOT = 4, VAC = 3, PULL = 2, FLT = 1;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] avs_address_in = 4'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic load_switch_in = 1'b0;
  logic operator_reset_in = 1'b0;
  logic power_good_reset_in = 1'b1;
  logic draw_en = 1'b1;
  logic [1:0] vacuum_switch_in;
  logic [31:0] avs_readdata_out;
  logic [31:0] rd;
  logic avs_waitrequest_out, marker_detected_in, vacuum_relay_out;
  logic blower_out, motor_relay_out, reel_pull_in_n_out, reel_drive_out;
  logic capstan_fwd_out, load_fault_n_out, motor_connect_n_out;
  logic rewind_clear_out, load_lamp_out;
  int bad_count = 0;
  int checks_done = 0;
  wire [6:0] mon = {load_lamp_out, capstan_fwd_out, motor_relay_out,
    vacuum_relay_out, reel_pull_in_n_out, load_fault_n_out,
    rewind_clear_out};
  tls_row_s rows [5] = '{
    '{4'h4, 4'hF, 1'b0, 32'h0, 32'h10},
    '{4'h0, 4'hF, 1'b1, 32'h7, 32'h1},
    '{4'h0, 4'h0, 1'b1, 32'h0, 32'h1},
    '{4'h0, 4'h1, 1'b1, 32'h0, 32'h0},
    '{4'h8, 4'hF, 1'b1, 32'h1, 32'h0}
  };
  tls_sequencer #(
    .DEBOUNCE_CYC(32'h4), .LOAD_DELAY_CYC(32'h14),
    .FAULT_CYC(32'h28), .HOLD_CYC(32'h1E)
  ) uut (
    .core_clk_in, .rst_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .load_switch_in, .operator_reset_in,
    .vacuum_switch_in, .marker_detected_in, .power_good_reset_in,
    .vacuum_relay_out, .blower_out, .motor_relay_out, .reel_pull_in_n_out,
    .reel_drive_out, .capstan_fwd_out, .load_fault_n_out,
    .motor_connect_n_out, .rewind_clear_out, .load_lamp_out
  );
  // default draw and marker spans suit the shortened timers
  tls_far_side far (
    .core_clk_in, .rst_in, .draw_en_in(draw_en),
    .reel_drive_in(reel_drive_out), .capstan_fwd_in(capstan_fwd_out),
    .vacuum_switch_out(vacuum_switch_in), .marker_out(marker_detected_in)
  );
  initial begin
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h", $time, what, seen);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [3:0] a, input logic w,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    @(posedge core_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= !w;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    rd = avs_readdata_out;
    check({31'h0, n < 50}, 32'h1, "bus answer");
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  task automatic wait_for(input int i, input logic v, input string what);
    int n;
    for (n = 0; n < 400 && mon[i] !== v; n++) @(posedge core_clk_in);
    check({31'h0, mon[i] === v}, 32'h1, what);
  endtask
  // press and release, each held past the debounce span
  task automatic press();
    load_switch_in <= 1'b1;
    repeat (DEB + 8) @(posedge core_clk_in);
    load_switch_in <= 1'b0;
    repeat (DEB + 8) @(posedge core_clk_in);
  endtask
  initial begin
    repeat (4) @(posedge core_clk_in);
    rst_in <= 1'b0;
    check({25'h0, mon}, 32'h6, "reset levels");
    foreach (rows[i]) begin
      if (rows[i].wr) bus(rows[i].a, 1'b1, rows[i].d, rows[i].be);
      bus(rows[i].a, 1'b0, 32'h0, 4'hF);
      check(rd, rows[i].exp, "register row");
    end
    press();
    wait_for(VAC, 1'b1, "vacuum on");
    wait_for(PULL, 1'b0, "pull-in");
    wait_for(MOT, 1'b1, "motor relay");
    repeat (3) @(posedge core_clk_in);
    check({30'h0, mon[PULL], mon[FLT]}, 32'h3, "pull-in end");
    wait_for(VAC, 1'b0, "hold expiry");
    wait_for(CAP, 1'b1, "threading");
    wait_for(LAMP, 1'b1, "marker lamp");
    check({31'h0, mon[CAP]}, 32'h0, "capstan stop");
    bus(4'h4, 1'b0, 32'h0, 4'hF);
    check(rd & 32'hD7, 32'hD4, "status loaded");
    power_good_reset_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    power_good_reset_in <= 1'b1;
    bus(4'h4, 1'b0, 32'h0, 4'hF);
    check(rd & 32'h47, 32'h0, "power loss");
    draw_en <= 1'b0;
    press();
    wait_for(FLT, 1'b0, "load fault");
    repeat (3) @(posedge core_clk_in);
    check({29'h0, mon[VAC], mon[CAP], mon[PULL]}, 32'h1, "abort");
    bus(4'h0, 1'b1, 32'h1, 4'hF);
    draw_en <= 1'b1;
    press();
    wait_for(MOT, 1'b1, "relay again");
    wait_for(VAC, 1'b0, "hold again");
    repeat (3) @(posedge core_clk_in);
    check({31'h0, mon[CAP]}, 32'h0, "no threading yet");
    press();
    wait_for(CAP, 1'b1, "second press");
    operator_reset_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    operator_reset_in <= 1'b0;
    check({31'h0, mon[CAP]}, 32'h0, "operator reset");
    report_and_stop();
  end
  // the sequence needs under 2000 cycles; allow ten times that
  initial begin
    #(20000 * 5);
    bad_count++;
    report_and_stop();
  end
endmodule
